// File: rtl/sjl_regs.svh
// Register offsets, field positions, reset values and link symbols of the link block.
`ifndef SJL_REGS_SVH
`define SJL_REGS_SVH

`define SJL_ADDR_W              12
`define SJL_ADDR_CTRL4          12'h574
`define SJL_ADDR_LMFC_OFFSET    12'h578
`define SJL_ADDR_STATUS         12'h57f
`define SJL_ADDR_DID            12'h580
`define SJL_ADDR_BID            12'h581
`define SJL_ADDR_LID0           12'h583
`define SJL_ADDR_LID1           12'h585

`define SJL_CTRL4_DELAY_MSB     7
`define SJL_CTRL4_DELAY_LSB     4
`define SJL_CTRL4_TEST_MSB      2
`define SJL_CTRL4_TEST_LSB      0

`define SJL_RST_CTRL4_DELAY     4'h0
`define SJL_RST_CTRL4_TEST      3'h0
`define SJL_RST_LMFC_OFFSET     5'h00
`define SJL_RST_DID             8'h00
`define SJL_RST_BID             4'h0
`define SJL_RST_LID0            5'h00
`define SJL_RST_LID1            5'h02

`define SJL_TEST_NORMAL         3'h0
`define SJL_TEST_D215           3'h1
`define SJL_TEST_RPAT           3'h4
`define SJL_TEST_JSPAT          3'h5
`define SJL_TEST_JTSPAT         3'h6

`define SJL_LMFC_LAST           5'h1f
`define SJL_ILAS_LAST_MF        2'h3

`define SJL_SYM_K285            8'hbc
`define SJL_SYM_R               8'h1c
`define SJL_SYM_A               8'h7c
`define SJL_SYM_Q               8'h9c
`define SJL_SYM_D215            8'hb5

`define SJL_FIFO_WIDTH          16
`define SJL_FIFO_DEPTH          16

`endif

// File: rtl/sjl_pkg.sv
// Types shared by the link block modules.
package sjl_pkg;

  typedef enum logic [1:0] {
    SJL_CGS,
    SJL_WAIT,
    SJL_ILAS,
    SJL_DATA
  } sjl_link_state_t;

  typedef struct packed {
    logic            sync_meta;
    logic            sync_q;
    logic            sysref_meta;
    logic            sysref_q;
    logic            sysref_prev;
    logic [4:0]      lmfc;
    logic [3:0]      bcnt;
    logic [1:0]      mf;
    sjl_link_state_t state;
    logic [4:0]      offset;
    logic [7:0]      did;
    logic [3:0]      bid;
    logic [4:0]      lid0;
    logic [4:0]      lid1;
    logic [3:0]      delay;
    logic [2:0]      test;
    logic [7:0]      rdata;
    logic [7:0]      lane0;
    logic [7:0]      lane1;
    logic [1:0]      lane_k;
    logic            lane_valid;
  } sjl_top_state_t;

  typedef struct packed {
    logic [3:0] idx;
    logic [6:0] lfsr;
    logic [7:0] octet;
  } sjl_seq_state_t;

endpackage : sjl_pkg

// File: rtl/sjl_fifo.sv
// Sample FIFO with valid and ready on both sides.
`timescale 1ns/1ps
`default_nettype none

module sjl_fifo
  import sjl_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] s_data,
  input  wire logic             s_valid,
  output logic                  s_ready,
  output logic      [WIDTH-1:0] m_data,
  output logic                  m_valid,
  input  wire logic             m_ready
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 count;
  } fifo_state_t;

  fifo_state_t s_q;
  fifo_state_t s_d;
  logic        push;
  logic        pop;

  assign s_ready = (s_q.count != DEPTH[AW:0]);
  assign m_valid = (s_q.count != '0);
  assign m_data  = s_q.mem[s_q.rd];
  assign push    = s_valid && s_ready;
  assign pop     = m_valid && m_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.mem[s_q.wr] = s_data;
      s_d.wr          = s_q.wr + AW'(1);
    end
    if (pop) begin
      s_d.rd = s_q.rd + AW'(1);
    end
    s_d.count = s_q.count + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : sjl_fifo

`default_nettype wire

// File: rtl/sjl_test_seq.sv
// Link-layer test sequence source, one octet per clock for every lane.
`timescale 1ns/1ps
`default_nettype none

`include "sjl_regs.svh"

module sjl_test_seq
  import sjl_pkg::*;
(
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic [2:0] mode,
  output logic      [7:0] octet
);

  // These are octet-level stand-ins placed ahead of the line encoder, so the
  // receiver sees the intended repeating shape but not exact coded disparity.
  localparam logic [11:0][7:0] RPAT_TAB = {
    8'hbe, 8'hd7, 8'h23, 8'h47, 8'h6b, 8'h8f,
    8'hb3, 8'h14, 8'h5e, 8'hfb, 8'h35, 8'h59
  };
  localparam logic [11:0][7:0] JT_TAB = {
    8'hb5, 8'hb5, 8'hb5, 8'hb5, 8'h4a, 8'h4a,
    8'h4a, 8'h4a, 8'h7e, 8'h7e, 8'h81, 8'h81
  };

  sjl_seq_state_t s_q;
  sjl_seq_state_t s_d;

  assign octet = s_q.octet;

  always_comb begin
    s_d      = s_q;
    s_d.lfsr = {s_q.lfsr[5:0], s_q.lfsr[6] ^ s_q.lfsr[5]};
    s_d.idx  = (s_q.idx == 4'hb) ? 4'h0 : s_q.idx + 4'h1;
    case (mode)
      `SJL_TEST_D215:  s_d.octet = `SJL_SYM_D215;
      `SJL_TEST_RPAT:  s_d.octet = RPAT_TAB[s_q.idx];
      `SJL_TEST_JSPAT: s_d.octet = `SJL_SYM_D215 ^ {1'b0, s_q.lfsr};
      `SJL_TEST_JTSPAT: s_d.octet = JT_TAB[s_q.idx] ^ {1'b0, s_q.lfsr};
      default:         s_d.octet = 8'h00;
    endcase
    if (mode == `SJL_TEST_NORMAL) begin
      s_d.idx = 4'h0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '{idx: 4'h0, lfsr: 7'h7f, octet: 8'h00};
    end else begin
      s_q <= s_d;
    end
  end

endmodule : sjl_test_seq

`default_nettype wire

// File: rtl/sjl_top.sv
// Serial link alignment, test sequence and identifier configuration block.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none

`include "sjl_regs.svh"

module sjl_top
  import sjl_pkg::*;
(
  input  wire logic                    clock,
  input  wire logic                    rst_n,
  input  wire logic [`SJL_ADDR_W-1:0]  reg_addr,
  input  wire logic [7:0]              reg_wdata,
  input  wire logic                    reg_wr,
  input  wire logic                    reg_rd,
  output logic      [7:0]              reg_rdata,
  input  wire logic                    sync_request_input_n,
  input  wire logic                    sysref,
  input  wire logic [`SJL_FIFO_WIDTH-1:0] sample_data,
  input  wire logic                    sample_valid,
  output logic                         sample_ready,
  output logic      [7:0]              lane0_octet,
  output logic      [7:0]              lane1_octet,
  output logic      [1:0]              lane_is_k,
  output logic                         lane_valid
);

  sjl_top_state_t s_q;
  sjl_top_state_t s_d;

  logic                        rst_meta_n;
  logic                        rst_sync_n;
  logic [`SJL_FIFO_WIDTH-1:0]  fifo_data;
  logic                        fifo_valid;
  logic                        fifo_pop;
  logic                        fifo_ready;
  logic                        ready_q;
  logic [7:0]                  seq_octet;
  logic                        sync_asserted;
  logic                        lmfc_last;
  logic [8:0]                  ilas0;
  logic [8:0]                  ilas1;

  // Reset is released through two flops so every state flop except ready_q
  // leaves reset on the same edge; asserting it still acts at once.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta_n <= 1'b0;
      rst_sync_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_sync_n <= rst_meta_n;
    end
  end

  // Builds one ILAS octet with its control flag for a lane.
  function automatic logic [8:0] ilas_octet(
    input logic [1:0] mf,
    input logic [4:0] pos,
    input logic [7:0] did,
    input logic [3:0] bid,
    input logic [4:0] lid
  );
    logic [8:0] r;
    r = {1'b0, 3'h0, pos};
    if (pos == 5'h00) begin
      r = {1'b1, `SJL_SYM_R};
    end else if (pos == `SJL_LMFC_LAST) begin
      r = {1'b1, `SJL_SYM_A};
    end else if (mf == 2'h1) begin
      case (pos)
        5'h01:   r = {1'b1, `SJL_SYM_Q};
        5'h02:   r = {1'b0, did};
        5'h03:   r = {1'b0, 4'h0, bid};
        5'h04:   r = {1'b0, 3'h0, lid};
        default: r = 9'h000;
      endcase
    end
    return r;
  endfunction : ilas_octet

  // Register read decode; unmapped addresses and reserved bits read zero.
  function automatic logic [7:0] reg_read(
    input logic [`SJL_ADDR_W-1:0] addr,
    input sjl_top_state_t         st
  );
    logic [7:0] r;
    r = 8'h00;
    case (addr)
      `SJL_ADDR_CTRL4:       r = {st.delay, 1'b0, st.test};
      `SJL_ADDR_LMFC_OFFSET: r = {3'h0, st.offset};
      `SJL_ADDR_STATUS:      r = {2'h0, st.state, st.sync_q, 3'h0};
      `SJL_ADDR_DID:         r = st.did;
      `SJL_ADDR_BID:         r = {4'h0, st.bid};
      `SJL_ADDR_LID0:        r = {3'h0, st.lid0};
      `SJL_ADDR_LID1:        r = {3'h0, st.lid1};
      default:               r = 8'h00;
    endcase
    return r;
  endfunction : reg_read

  sjl_fifo #(
    .WIDTH (`SJL_FIFO_WIDTH),
    .DEPTH (`SJL_FIFO_DEPTH)
  ) u_fifo (
    .clock   (clock),
    .rst_n   (rst_sync_n),
    .s_data  (sample_data),
    .s_valid (sample_valid),
    .s_ready (fifo_ready),
    .m_data  (fifo_data),
    .m_valid (fifo_valid),
    .m_ready (fifo_pop)
  );

  sjl_test_seq u_seq (
    .clock (clock),
    .rst_n (rst_sync_n),
    .mode  (s_q.test),
    .octet (seq_octet)
  );

  // The FIFO ready is registered so the output stays a flop; a source may
  // therefore push once into a FIFO that has just filled, which the FIFO
  // itself refuses, so the source must hold its word until ready returns.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= fifo_ready && rst_sync_n;
    end
  end

  assign sample_ready  = ready_q;
  assign sync_asserted = !s_q.sync_q;
  assign lmfc_last     = (s_q.lmfc == `SJL_LMFC_LAST);
  // The buffer drains only in the data phase with no test mode, so words
  // queued during alignment or a test wait for the link to come up.
  assign fifo_pop      = (s_q.state == SJL_DATA) && (s_q.test == `SJL_TEST_NORMAL) && fifo_valid;
  assign ilas0         = ilas_octet(s_q.mf, s_q.lmfc, s_q.did, s_q.bid, s_q.lid0);
  assign ilas1         = ilas_octet(s_q.mf, s_q.lmfc, s_q.did, s_q.bid, s_q.lid1);

  assign reg_rdata   = s_q.rdata;
  assign lane0_octet = s_q.lane0;
  assign lane1_octet = s_q.lane1;
  assign lane_is_k   = s_q.lane_k;
  assign lane_valid  = s_q.lane_valid;

  always_comb begin
    s_d = s_q;

    // Both pins are asynchronous and pass two flops before any use.
    s_d.sync_meta   = sync_request_input_n;
    s_d.sync_q      = s_q.sync_meta;
    s_d.sysref_meta = sysref;
    s_d.sysref_q    = s_q.sysref_meta;
    s_d.sysref_prev = s_q.sysref_q;

    // The offset loads on the synchronised rising edge only, so a long
    // SYSREF pulse does not hold the counter still.
    if (s_q.sysref_q && !s_q.sysref_prev) begin
      s_d.lmfc = s_q.offset;
    end else begin
      s_d.lmfc = s_q.lmfc + 5'h01;
    end

    // Writes land on the strobe edge; the status register is read only, so
    // a write to it falls to the default branch and changes nothing.
    if (reg_wr) begin
      case (reg_addr)
        `SJL_ADDR_CTRL4: begin
          s_d.delay = reg_wdata[`SJL_CTRL4_DELAY_MSB:`SJL_CTRL4_DELAY_LSB];
          s_d.test  = reg_wdata[`SJL_CTRL4_TEST_MSB:`SJL_CTRL4_TEST_LSB];
        end
        `SJL_ADDR_LMFC_OFFSET: s_d.offset = reg_wdata[4:0];
        `SJL_ADDR_DID:         s_d.did    = reg_wdata;
        `SJL_ADDR_BID:         s_d.bid    = reg_wdata[3:0];
        `SJL_ADDR_LID0:        s_d.lid0   = reg_wdata[4:0];
        `SJL_ADDR_LID1:        s_d.lid1   = reg_wdata[4:0];
        default:               s_d.test   = s_q.test;
      endcase
    end

    s_d.rdata = 8'h00;
    if (reg_rd) begin
      s_d.rdata = reg_read(reg_addr, s_q);
    end

    case (s_q.state)
      SJL_CGS: begin
        if (!sync_asserted) begin
          s_d.state = SJL_WAIT;
          s_d.bcnt  = 4'h0;
        end
      end
      SJL_WAIT: begin
        // The boundary falls on the edge after the last LMFC count.
        if (lmfc_last) begin
          if (s_q.bcnt == s_q.delay) begin
            s_d.state = SJL_ILAS;
            s_d.mf    = 2'h0;
          end else begin
            s_d.bcnt = s_q.bcnt + 4'h1;
          end
        end
      end
      SJL_ILAS: begin
        if (lmfc_last) begin
          if (s_q.mf == `SJL_ILAS_LAST_MF) begin
            s_d.state = SJL_DATA;
          end else begin
            s_d.mf = s_q.mf + 2'h1;
          end
        end
      end
      SJL_DATA: begin
        // Only a renewed sync request or a reset leaves the data phase.
        s_d.state = SJL_DATA;
      end
      default: begin
        s_d.state = SJL_CGS;
      end
    endcase

    if (sync_asserted) begin
      s_d.state = SJL_CGS;
    end

    s_d.lane_valid = 1'b1;
    // A test mode overrides every state, code group sync included, so a
    // receiver under test sees the sequence even while it holds the request.
    if (s_q.test != `SJL_TEST_NORMAL) begin
      s_d.lane0  = seq_octet;
      s_d.lane1  = seq_octet;
      s_d.lane_k = 2'b00;
    end else begin
      case (s_q.state)
        SJL_ILAS: begin
          s_d.lane0  = ilas0[7:0];
          s_d.lane1  = ilas1[7:0];
          s_d.lane_k = {ilas1[8], ilas0[8]};
        end
        SJL_DATA: begin
          s_d.lane0      = fifo_data[7:0];
          s_d.lane1      = fifo_data[15:8];
          s_d.lane_k     = 2'b00;
          s_d.lane_valid = fifo_valid;
        end
        default: begin
          // Code group synchronization continues until the alignment start.
          s_d.lane0  = `SJL_SYM_K285;
          s_d.lane1  = `SJL_SYM_K285;
          s_d.lane_k = 2'b11;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      s_q.sync_meta   <= 1'b0;
      s_q.sync_q      <= 1'b0;
      s_q.sysref_meta <= 1'b0;
      s_q.sysref_q    <= 1'b0;
      s_q.sysref_prev <= 1'b0;
      s_q.lmfc        <= 5'h00;
      s_q.bcnt        <= 4'h0;
      s_q.mf          <= 2'h0;
      s_q.state       <= SJL_CGS;
      s_q.rdata       <= 8'h00;
      s_q.lane0       <= 8'h00;
      s_q.lane1       <= 8'h00;
      s_q.lane_k      <= 2'b00;
      s_q.lane_valid  <= 1'b0;
      s_q.offset      <= `SJL_RST_LMFC_OFFSET;
      s_q.did         <= `SJL_RST_DID;
      s_q.bid         <= `SJL_RST_BID;
      s_q.lid0        <= `SJL_RST_LID0;
      s_q.lid1        <= `SJL_RST_LID1;
      s_q.delay       <= `SJL_RST_CTRL4_DELAY;
      s_q.test        <= `SJL_RST_CTRL4_TEST;
    end else begin
      s_q <= s_d;
    end
  end

endmodule : sjl_top

`default_nettype wire

// File: verification/sjl_top_monitor.sv
// Port-level checker for the link block, bound into the top module.
`timescale 1ns/1ps
`default_nettype none
`include "sjl_regs.svh"

module sjl_top_monitor (
  input wire logic                   clock,
  input wire logic                   rst_n,
  input wire logic [`SJL_ADDR_W-1:0] reg_addr,
  input wire logic [7:0]             reg_wdata,
  input wire logic                   reg_wr,
  input wire logic                   reg_rd,
  input wire logic [7:0]             reg_rdata,
  input wire logic                   sync_request_input_n,
  input wire logic [7:0]             lane0_octet,
  input wire logic [7:0]             lane1_octet,
  input wire logic [1:0]             lane_is_k,
  input wire logic                   lane_valid
);
  logic [2:0] mode_q;

  // Shadow of the test field, so lane checks know which traffic is due.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_q <= 3'h0;
    end else if (reg_wr && reg_addr == 12'h574) begin
      mode_q <= reg_wdata[2:0];
    end
  end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_bid_reserved: assert property (
    $past(reg_rd) && $past(reg_addr) == 12'h581 |-> reg_rdata[7:4] == 4'h0)
    else $error("bank id upper bits not zero");
  a_lid_reserved: assert property (
    $past(reg_rd) && $past(reg_addr) == 12'h585 |-> reg_rdata[7:5] == 3'h0)
    else $error("lane id upper bits not zero");
  a_cgs_chars: assert property (
    (!sync_request_input_n && mode_q == 3'h0) [*6] |->
      lane0_octet == 8'hbc && lane1_octet == 8'hbc && lane_is_k == 2'b11)
    else $error("no sync characters while request held");
  a_cgs_on_sync: assert property (
    $fell(sync_request_input_n) && mode_q == 3'h0 |->
      ##[1:6] lane0_octet == 8'hbc && lane_is_k == 2'b11)
    else $error("request did not restart sync characters");
  a_d215_stream: assert property (
    (mode_q == 3'h1) [*3] |-> lane0_octet == 8'hb5 && lane1_octet == 8'hb5)
    else $error("test stream is not the fixed character");
  a_test_all_lanes: assert property (
    (mode_q != 3'h0) [*3] |-> lane_is_k == 2'b00 && lane0_octet == lane1_octet)
    else $error("test sequence not on every lane");
  a_ilas_after_rel: assert property (
    lane0_octet == 8'h1c && lane_is_k == 2'b11 |-> $past(sync_request_input_n, 3))
    else $error("alignment start while request held");
  a_k_lanes_pair: assert property (
    lane_is_k == 2'b00 || lane_is_k == 2'b11)
    else $error("control flags differ between lanes");

  c_ilas: cover property (lane0_octet == 8'h1c && lane_is_k == 2'b11);
  c_d215: cover property (mode_q == 3'h1 ##3 lane0_octet == 8'hb5);
  c_data: cover property (lane_valid && sync_request_input_n && lane_is_k == 2'b00);
endmodule : sjl_top_monitor

bind sjl_top sjl_top_monitor mon_u (
  .clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .sync_request_input_n(sync_request_input_n), .lane0_octet(lane0_octet),
  .lane1_octet(lane1_octet), .lane_is_k(lane_is_k), .lane_valid(lane_valid));

`default_nettype wire

// File: verification/sjl_rx_model.sv
// Receiver model: holds the sync request and counts alignment multiframe ends.
`timescale 1ns/1ps
`default_nettype none

module sjl_rx_model (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       go,
  input wire logic [7:0] lane0_octet,
  input wire logic [1:0] lane_is_k,
  output logic           sync_request_input_n,
  output int             n_align
);
  // The request stays asserted until the bench says the receiver is ready.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_request_input_n <= 1'b0;
      n_align <= 0;
    end else begin
      sync_request_input_n <= go;
      if (!sync_request_input_n) begin
        n_align <= 0;
      end else if (lane0_octet == 8'h7c && lane_is_k == 2'b11) begin
        n_align <= n_align + 1;
      end
    end
  end
endmodule : sjl_rx_model

`default_nettype wire

// File: verification/sjl_top_test.sv
// Self-checking bench for the link alignment and identifier block.
`timescale 1ns/1ps
`default_nettype none

module sjl_top_test;
  logic        clock, rst_n, reg_wr, reg_rd, sysref, go, sync_n;
  logic        sample_valid, sample_ready, lane_valid;
  logic [11:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, lane0_octet, lane1_octet;
  logic [15:0] sample_data;
  logic [1:0]  lane_is_k;
  int          n_errors, total_checks, cyc, n_align;

  sjl_top dut_u (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sync_request_input_n(sync_n), .sysref(sysref), .sample_data(sample_data),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .lane0_octet(lane0_octet), .lane1_octet(lane1_octet),
    .lane_is_k(lane_is_k), .lane_valid(lane_valid));
  sjl_rx_model rx_u (.clock(clock), .rst_n(rst_n), .go(go),
    .lane0_octet(lane0_octet), .lane_is_k(lane_is_k),
    .sync_request_input_n(sync_n), .n_align(n_align));

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      final_report();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic chkn(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chkn

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rdc(input logic [11:0] a, input logic [7:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : rdc

  task automatic t_regs();
    logic [11:0] a [6] = '{12'h574, 12'h578, 12'h580, 12'h581, 12'h583, 12'h585};
    logic [7:0]  rv [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h02};
    logic [7:0]  ev [6] = '{8'hf6, 8'h1f, 8'hff, 8'h0f, 8'h1f, 8'h1f};
    for (int i = 0; i < 6; i++) rdc(a[i], rv[i]);
    rdc(12'h57f, 8'h00);
    // Bit 0 of the control write stays clear so no reserved test code is set.
    for (int i = 0; i < 6; i++) begin
      wr(a[i], (i == 0) ? 8'hfe : 8'hff);
      rdc(a[i], ev[i]);
    end
    wr(12'h590, 8'haa);
    rdc(12'h590, 8'h00);
    for (int i = 0; i < 6; i++) wr(a[i], rv[i]);
    $display("regs test done");
  endtask : t_regs

  task automatic run_ilas(input logic [3:0] dly, input logic [4:0] off, output int t);
    @(posedge clock);
    go <= 1'b0;
    wr(12'h574, {dly, 4'h0});
    wr(12'h578, {3'h0, off});
    repeat (6) @(posedge clock);
    sysref <= 1'b1;
    @(posedge clock);
    sysref <= 1'b0;
    repeat (3) @(posedge clock);
    go <= 1'b1;
    t = 0;
    while (t < 700 && !(lane0_octet === 8'h1c && lane_is_k === 2'b11)) begin
      @(posedge clock);
      #1 t++;
    end
  endtask : run_ilas

  task automatic t_ilas();
    int t0, t4, t15, tf;
    run_ilas(4'h0, 5'h00, t0);
    run_ilas(4'h4, 5'h00, t4);
    run_ilas(4'hf, 5'h00, t15);
    run_ilas(4'h0, 5'h05, tf);
    chkn(int'(t0 <= 38), 1);
    chkn(t4 - t0, 128);
    chkn(t15 - t0, 480);
    chkn((t0 - tf + 32) % 32, 5);
    wr(12'h578, 8'h00);
    $display("ilas test done");
  endtask : t_ilas

  task automatic t_data();
    int n;
    @(posedge clock);
    go <= 1'b0;
    repeat (6) @(posedge clock);
    n = 0;
    // Fill while the link is held in sync, so nothing drains the buffer.
    while (n < 20) begin
      sample_valid <= 1'b1;
      sample_data <= {8'hc0 + 8'(n), 8'h30 + 8'(n)};
      @(negedge clock);
      if (sample_ready !== 1'b1) break;
      @(posedge clock);
      n++;
    end
    chk({7'h0, sample_ready}, 8'h00);
    @(posedge clock);
    sample_valid <= 1'b0;
    go <= 1'b1;
    n = 0;
    while (n < 400 && n_align != 4) begin
      @(posedge clock);
      #1 n++;
    end
    n = 0;
    repeat (20) begin
      if (lane_valid === 1'b1 && lane_is_k === 2'b00) begin
        chk(lane0_octet, 8'h30 + 8'(n));
        chk(lane1_octet, 8'hc0 + 8'(n));
        n++;
      end
      @(posedge clock);
      #1;
    end
    chkn(n, 16);
    chk({7'h0, lane_valid}, 8'h00);
    rdc(12'h57f, 8'h38);
    chk({7'h0, sample_ready}, 8'h01);
    $display("data test done");
  endtask : t_data

  task automatic t_modes();
    logic [2:0] m [4] = '{3'h1, 3'h4, 3'h5, 3'h6};
    for (int i = 0; i < 4; i++) begin
      wr(12'h574, {5'h0, m[i]});
      repeat (3) @(posedge clock);
      #1;
      chk({6'h0, lane_is_k}, 8'h00);
      if (m[i] == 3'h1) chk(lane0_octet, 8'hb5);
      if (m[i] == 3'h1) chk(lane1_octet, 8'hb5);
      chk(lane1_octet, lane0_octet);
    end
    wr(12'h574, 8'h00);
    go <= 1'b0;
    repeat (6) @(posedge clock);
    #1;
    chk(lane0_octet, 8'hbc);
    chk({6'h0, lane_is_k}, 8'h03);
    $display("modes test done");
  endtask : t_modes

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  initial begin
    {rst_n, reg_wr, reg_rd, sysref, go, sample_valid} = 6'h0;
    {reg_addr, reg_wdata, sample_data} = 36'h0;
    {n_errors, total_checks, cyc} = {32'h0, 32'h0, 32'h0};
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    t_regs();
    t_ilas();
    t_data();
    t_modes();
    final_report();
  end
endmodule : sjl_top_test

`default_nettype wire
